/* core/sbc_bit_engine.sv */
// bit engine: start, stop and byte transfers on the open-drain two-wire bus
`timescale 1ns/1ns
`default_nettype none
module sbc_bit_engine #(
  parameter int QTR_NORMAL = sbc_pkg::SBC_QTR_NORMAL,
  parameter int QTR_FAST = sbc_pkg::SBC_QTR_FAST
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // rate select
  input wire logic i_fast,
  // command and answer
  input wire logic i_req_valid,
  input wire sbc_pkg::sbc_req_s i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output sbc_pkg::sbc_rsp_s o_rsp,
  // bus pins, data input already synchronised
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe
);
  import sbc_pkg::*;

  typedef enum logic [1:0] {
    SBC_E_IDLE = 2'b00,
    SBC_E_START = 2'b01,
    SBC_E_BIT = 2'b11,
    SBC_E_STOP = 2'b10
  } sbc_eng_e;

  localparam logic [SBC_QTR_W-1:0] QN = SBC_QTR_W'(QTR_NORMAL - 1);
  localparam logic [SBC_QTR_W-1:0] QF = SBC_QTR_W'(QTR_FAST - 1);
  localparam logic [3:0] ACK_BIT = 4'(SBC_DATA_BITS);

  sbc_eng_e state_reg, state_next;
  sbc_cmd_e cmd_reg, cmd_next;
  logic [SBC_QTR_W-1:0] qtr_reg, qtr_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic scl_reg, scl_next, sda_reg, sda_next, nack_reg, nack_next, done_reg, done_next;
  logic tick, fin;

  // sequence quarters of each bit; the rate is read at every reload
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    qtr_next = qtr_reg;
    phase_next = phase_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    fin = 1'b0;
    tick = (qtr_reg == '0);
    if (state_reg != SBC_E_IDLE) begin
      if (tick) begin
        qtr_next = i_fast ? QF : QN;
        phase_next = phase_reg + 2'd1;
      end else begin
        qtr_next = qtr_reg - 1'b1;
      end
    end
    unique case (state_reg)
      SBC_E_IDLE: begin
        if (i_req_valid) begin
          cmd_next = i_req.cmd;
          shift_next = i_req.data;
          bit_next = '0;
          phase_next = '0;
          nack_next = 1'b0;
          qtr_next = i_fast ? QF : QN;
          if (i_req.cmd == SBC_CMD_START) begin
            state_next = SBC_E_START;
          end else if (i_req.cmd == SBC_CMD_STOP) begin
            state_next = SBC_E_STOP;
          end else begin
            state_next = SBC_E_BIT;
          end
        end
      end
      // release data, raise clock, pull data low under high clock, lower clock
      SBC_E_START: begin
        if (tick) begin
          unique case (phase_reg)
            2'd0: sda_next = 1'b1;
            2'd1: scl_next = 1'b1;
            2'd2: sda_next = 1'b0;
            2'd3: begin
              scl_next = 1'b0;
              fin = 1'b1;
            end
          endcase
        end
      end
      // data low, clock high, then data rises while clock is high
      SBC_E_STOP: begin
        if (tick) begin
          unique case (phase_reg)
            2'd0: sda_next = 1'b0;
            2'd1: scl_next = 1'b1;
            2'd2: sda_next = 1'b1;
            2'd3: fin = 1'b1;
          endcase
        end
      end
      // eight data bits msb first, then the acknowledge slot
      SBC_E_BIT: begin
        if (tick) begin
          unique case (phase_reg)
            2'd0: sda_next = (cmd_reg == SBC_CMD_WRITE && bit_reg < ACK_BIT) ? shift_reg[7] : 1'b1;
            2'd1: scl_next = 1'b1;
            2'd2: begin
              if (bit_reg < ACK_BIT) begin
                shift_next = {shift_reg[6:0], (cmd_reg == SBC_CMD_READ) & i_sda};
              end else begin
                // a single-byte read always answers with no acknowledge
                nack_next = (cmd_reg == SBC_CMD_WRITE) & i_sda;
              end
            end
            2'd3: begin
              scl_next = 1'b0;
              if (bit_reg == ACK_BIT) begin
                fin = 1'b1;
              end else begin
                bit_next = bit_reg + 4'd1;
              end
            end
          endcase
        end
      end
    endcase
    if (fin) begin
      state_next = SBC_E_IDLE;
      done_next = 1'b1;
    end
  end

  // register the engine state; the bus idles released
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= SBC_E_IDLE;
      cmd_reg <= SBC_CMD_START;
      qtr_reg <= '0;
      phase_reg <= '0;
      bit_reg <= '0;
      shift_reg <= SBC_BYTE_RESET;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      qtr_reg <= qtr_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
    end
  end

  // open drain: enable only to pull low
  assign o_req_ready = (state_reg == SBC_E_IDLE);
  assign o_rsp_valid = done_reg;
  assign o_rsp = '{nack: nack_reg, data: shift_reg};
  assign o_scl = 1'b0;
  assign o_scl_oe = ~scl_reg;
  assign o_sda = 1'b0;
  assign o_sda_oe = ~sda_reg;

endmodule : sbc_bit_engine
`default_nettype wire

/* core/sbc_ctrl_status.sv */
// serial-bus control and status registers with the transfer sequencer
// Functional notes
// - address mode bit 7 low sends slave then word address, high sends only the slave address.
// - bit 6 of the control and status register always reads zero.
// - request busy (bit 5) reads one while a software-started cycle runs.
// - eeprom busy (bit 4) reads one while register defaults are being loaded.
// - eeprom present (bit 3) is set when an eeprom answers at fundamental reset release.
// - fast clock test (bit 2) selects about 4 MHz instead of about 60 kHz for the serial clock.
// - transfer error (bit 1) is set by a failed software cycle and held until software clears it.
// - load error (bit 0) is set by a failed eeprom download and held until software clears it.
// - every implemented bit returns to zero on fundamental, global or power-on reset.
// - slave address bit 0 picks write (0) or read (1), bits 7:1 hold the slave address.
// - a read places the received byte in the data register before request busy clears.
`timescale 1ns/1ns
`default_nettype none
module sbc_ctrl_status #(
  parameter int QTR_NORMAL = sbc_pkg::SBC_QTR_NORMAL,
  parameter int QTR_FAST = sbc_pkg::SBC_QTR_FAST,
  parameter logic [6:0] PROBE_ADDR = 7'h50
) (
  // clock, enable and resets (i_rst is the power-on reset)
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_fundamental_reset,
  input wire logic i_global_reset,
  // configuration register port
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  // register-default loader status
  input wire logic i_load_busy,
  input wire logic i_load_error,
  // serial bus pins
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe
);
  import sbc_pkg::*;

  typedef enum logic [2:0] {
    SBC_S_IDLE = 3'b000,
    SBC_S_START = 3'b001,
    SBC_S_SLAVE = 3'b011,
    SBC_S_WORD = 3'b010,
    SBC_S_DATA = 3'b110,
    SBC_S_STOP = 3'b100
  } sbc_seq_e;

  // pin synchronisers: data line, fundamental reset, global reset
  logic [2:0] sync1_reg, sync2_reg;
  logic sda_s, fund_s, glob_s, rst_all;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_reg <= 3'b001;
      sync2_reg <= 3'b001;
    end else if (i_ce) begin
      sync1_reg <= {i_global_reset, i_fundamental_reset, i_sda};
      sync2_reg <= sync1_reg;
    end
  end

  assign sda_s = sync2_reg[0];
  assign fund_s = sync2_reg[1];
  assign glob_s = sync2_reg[2];
  assign rst_all = i_rst | fund_s | glob_s;

  sbc_seq_e seq_reg, seq_next;
  logic [7:0] data_reg, data_next, word_reg, word_next, slave_reg, slave_next;
  logic [7:0] rdata_reg, rdata_next, csr;
  logic mode_reg, mode_next, fast_reg, fast_next, present_reg, present_next;
  logic xerr_reg, xerr_next, lerr_reg, lerr_next, busy_reg, busy_next;
  logic probe_reg, probe_next, cur_probe_reg, cur_probe_next;
  logic restart_reg, restart_next, sent_reg, sent_next, fund_prev_reg;
  logic eng_valid, eng_ready, eng_done, is_read;
  sbc_req_s eng_req;
  sbc_rsp_s eng_rsp;

  // status view of the control and status register
  always_comb begin
    csr = SBC_BYTE_RESET;
    csr[SBC_BIT_MODE] = mode_reg;
    csr[SBC_BIT_RSVD] = 1'b0;
    csr[SBC_BIT_REQ_BUSY] = busy_reg;
    csr[SBC_BIT_ROM_BUSY] = probe_reg | i_load_busy;
    csr[SBC_BIT_PRESENT] = present_reg;
    csr[SBC_BIT_FAST] = fast_reg;
    csr[SBC_BIT_XFER_ERR] = xerr_reg;
    csr[SBC_BIT_LOAD_ERR] = lerr_reg;
  end

  // register writes first, then hardware events, so a set in the clear cycle wins
  always_comb begin
    seq_next = seq_reg;
    data_next = data_reg;
    word_next = word_reg;
    slave_next = slave_reg;
    mode_next = mode_reg;
    fast_next = fast_reg;
    present_next = present_reg;
    xerr_next = xerr_reg;
    lerr_next = lerr_reg;
    busy_next = busy_reg;
    probe_next = probe_reg;
    cur_probe_next = cur_probe_reg;
    restart_next = restart_reg;
    sent_next = sent_reg;
    rdata_next = rdata_reg;
    eng_valid = 1'b0;
    eng_req = '{cmd: SBC_CMD_START, data: SBC_BYTE_RESET};
    is_read = slave_reg[SBC_BIT_RW] & ~cur_probe_reg;
    if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        SBC_OFS_DATA: data_next = i_cfg_wdata;
        SBC_OFS_WORD: word_next = i_cfg_wdata;
        SBC_OFS_SLAVE: begin
          // slave write starts the cycle; refused while the bus is in use
          if (!busy_reg && !probe_reg && seq_reg == SBC_S_IDLE) begin
            slave_next = i_cfg_wdata;
            busy_next = 1'b1;
          end
        end
        SBC_OFS_CSR: begin
          mode_next = i_cfg_wdata[SBC_BIT_MODE];
          fast_next = i_cfg_wdata[SBC_BIT_FAST];
          present_next = i_cfg_wdata[SBC_BIT_PRESENT];
          if (i_cfg_wdata[SBC_BIT_XFER_ERR]) xerr_next = 1'b0;
          if (i_cfg_wdata[SBC_BIT_LOAD_ERR]) lerr_next = 1'b0;
        end
        default: ;
      endcase
    end
    if (fund_prev_reg && !fund_s) probe_next = 1'b1;
    if (i_load_error) lerr_next = 1'b1;
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        SBC_OFS_DATA: rdata_next = data_reg;
        SBC_OFS_WORD: rdata_next = word_reg;
        SBC_OFS_SLAVE: rdata_next = slave_reg;
        SBC_OFS_CSR: rdata_next = csr;
        default: rdata_next = SBC_BYTE_RESET;
      endcase
    end
    // each state but idle issues one engine command, then waits for its answer
    if (seq_reg != SBC_S_IDLE && !sent_reg) begin
      eng_valid = 1'b1;
      if (eng_ready) sent_next = 1'b1;
    end
    if (eng_done) sent_next = 1'b0;
    unique case (seq_reg)
      SBC_S_IDLE: begin
        if (probe_reg || busy_reg) begin
          cur_probe_next = probe_reg;
          restart_next = 1'b0;
          seq_next = SBC_S_START;
        end
      end
      SBC_S_START: begin
        if (eng_done) seq_next = SBC_S_SLAVE;
      end
      SBC_S_SLAVE: begin
        // address field and direction bit; the direction goes out only on the final address
        eng_req = '{cmd: SBC_CMD_WRITE, data: cur_probe_reg ? {PROBE_ADDR, 1'b0} :
                    {slave_reg[SBC_ADDR_MSB:SBC_ADDR_LSB], is_read & (mode_reg | restart_reg)}};
        if (eng_done) begin
          if (eng_rsp.nack) begin
            if (!cur_probe_reg) xerr_next = 1'b1;
            seq_next = SBC_S_STOP;
          end else if (cur_probe_reg) begin
            present_next = 1'b1;
            seq_next = SBC_S_STOP;
          end else if (!mode_reg && !restart_reg) begin
            seq_next = SBC_S_WORD;
          end else begin
            seq_next = SBC_S_DATA;
          end
        end
      end
      SBC_S_WORD: begin
        eng_req = '{cmd: SBC_CMD_WRITE, data: word_reg};
        if (eng_done) begin
          if (eng_rsp.nack) begin
            xerr_next = 1'b1;
            seq_next = SBC_S_STOP;
          end else if (is_read) begin
            // repeated start turns the bus round for the read
            restart_next = 1'b1;
            seq_next = SBC_S_START;
          end else begin
            seq_next = SBC_S_DATA;
          end
        end
      end
      SBC_S_DATA: begin
        eng_req = '{cmd: is_read ? SBC_CMD_READ : SBC_CMD_WRITE, data: data_reg};
        if (eng_done) begin
          // received byte lands before busy clears; it overrides a same-cycle write
          if (is_read) data_next = eng_rsp.data;
          else if (eng_rsp.nack) xerr_next = 1'b1;
          seq_next = SBC_S_STOP;
        end
      end
      SBC_S_STOP: begin
        eng_req = '{cmd: SBC_CMD_STOP, data: SBC_BYTE_RESET};
        if (eng_done) begin
          if (cur_probe_reg) probe_next = 1'b0;
          else busy_next = 1'b0;
          seq_next = SBC_S_IDLE;
        end
      end
    endcase
  end

  // register state; the edge detector for reset release only follows power-on reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fund_prev_reg <= 1'b0;
    end else if (i_ce) begin
      fund_prev_reg <= fund_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      seq_reg <= SBC_S_IDLE;
      data_reg <= SBC_BYTE_RESET;
      word_reg <= SBC_BYTE_RESET;
      slave_reg <= SBC_BYTE_RESET;
      rdata_reg <= SBC_BYTE_RESET;
      mode_reg <= 1'b0;
      fast_reg <= 1'b0;
      present_reg <= 1'b0;
      xerr_reg <= 1'b0;
      lerr_reg <= 1'b0;
      busy_reg <= 1'b0;
      probe_reg <= 1'b0;
      cur_probe_reg <= 1'b0;
      restart_reg <= 1'b0;
      sent_reg <= 1'b0;
    end else if (i_ce) begin
      seq_reg <= seq_next;
      data_reg <= data_next;
      word_reg <= word_next;
      slave_reg <= slave_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      fast_reg <= fast_next;
      present_reg <= present_next;
      xerr_reg <= xerr_next;
      lerr_reg <= lerr_next;
      busy_reg <= busy_next;
      probe_reg <= probe_next;
      cur_probe_reg <= cur_probe_next;
      restart_reg <= restart_next;
      sent_reg <= sent_next;
    end
  end

  assign o_cfg_rdata = rdata_reg;

  // rate select into the bit engine
  sbc_bit_engine #(
    .QTR_NORMAL(QTR_NORMAL),
    .QTR_FAST(QTR_FAST)
  ) u_engine (
    .i_clk(i_clk),
    .i_rst(rst_all),
    .i_ce(i_ce),
    .i_fast(fast_reg),
    .i_req_valid(eng_valid),
    .i_req(eng_req),
    .o_req_ready(eng_ready),
    .o_rsp_valid(eng_done),
    .o_rsp(eng_rsp),
    .i_sda(sda_s),
    .o_scl(o_scl),
    .o_scl_oe(o_scl_oe),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe)
  );

endmodule : sbc_ctrl_status
`default_nettype wire

/* core/sbc_pkg.sv */
// shared constants, commands and carriers for the serial-bus control block
package sbc_pkg;

  // configuration register offsets
  localparam logic [7:0] SBC_OFS_DATA = 8'hB0;
  localparam logic [7:0] SBC_OFS_WORD = 8'hB1;
  localparam logic [7:0] SBC_OFS_SLAVE = 8'hB2;
  localparam logic [7:0] SBC_OFS_CSR = 8'hB3;

  // control and status bit positions
  localparam int SBC_BIT_MODE = 7;
  localparam int SBC_BIT_RSVD = 6;
  localparam int SBC_BIT_REQ_BUSY = 5;
  localparam int SBC_BIT_ROM_BUSY = 4;
  localparam int SBC_BIT_PRESENT = 3;
  localparam int SBC_BIT_FAST = 2;
  localparam int SBC_BIT_XFER_ERR = 1;
  localparam int SBC_BIT_LOAD_ERR = 0;

  // slave address register fields
  localparam int SBC_BIT_RW = 0;
  localparam int SBC_ADDR_MSB = 7;
  localparam int SBC_ADDR_LSB = 1;

  // reset values
  localparam logic [7:0] SBC_BYTE_RESET = 8'h00;

  // timing: core clock and the two serial clock rates, each bit is four quarters
  localparam int SBC_CLK_KHZ = 100000;
  localparam int SBC_NORMAL_SCL_KHZ = 60;
  localparam int SBC_FAST_SCL_KHZ = 4000;
  localparam int SBC_QUARTERS = 4;
  localparam int SBC_QTR_NORMAL = SBC_CLK_KHZ / (SBC_QUARTERS * SBC_NORMAL_SCL_KHZ);
  localparam int SBC_QTR_FAST = SBC_CLK_KHZ / (SBC_QUARTERS * SBC_FAST_SCL_KHZ);
  localparam int SBC_QTR_W = 16;
  localparam int SBC_DATA_BITS = 8;

  // byte-level commands to the bit engine
  typedef enum logic [1:0] {
    SBC_CMD_START = 2'b00,
    SBC_CMD_WRITE = 2'b01,
    SBC_CMD_READ = 2'b11,
    SBC_CMD_STOP = 2'b10
  } sbc_cmd_e;

  typedef struct packed {
    sbc_cmd_e cmd;
    logic [7:0] data;
  } sbc_req_s;

  typedef struct packed {
    logic nack;
    logic [7:0] data;
  } sbc_rsp_s;

endpackage : sbc_pkg

/* dv/sbc_ctrl_status_checker.sv */
// port-level assertions for the serial-bus control and status block
`timescale 1ns/1ns
`default_nettype none
module sbc_ctrl_status_checker (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fundamental_reset,
  input wire logic i_global_reset,
  // register port
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [7:0] o_cfg_rdata,
  // loader and bus
  input wire logic i_load_busy,
  input wire logic i_load_error,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe
);
  import sbc_pkg::*;
  logic any_rst;
  logic [6:0] idle_reg, idle_next;
  logic err_reg, err_next;
  logic [1:0] age_reg, age_next;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  assign any_rst = i_rst | i_fundamental_reset | i_global_reset;
  // bus idle time and the expected sticky load error
  always_comb begin
    idle_next = idle_reg + {6'h00, idle_reg != 7'h7f};
    if (any_rst || o_scl_oe || o_sda_oe) idle_next = 7'h00;
    err_next = err_reg;
    if (i_cfg_wr && i_cfg_addr == SBC_OFS_CSR && i_cfg_wdata[0]) err_next = 1'b0;
    if (i_load_error) err_next = 1'b1;
    if (any_rst) err_next = 1'b0;
    age_next = (err_next != err_reg) ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
    if (any_rst) age_next = 2'h0;
  end
  always_ff @(posedge i_clk) begin
    idle_reg <= idle_next;
    err_reg <= err_next;
    age_reg <= age_next;
  end
  sequence s_csr_read;
    i_cfg_rd && i_cfg_addr == SBC_OFS_CSR;
  endsequence
  sequence s_slave_write;
    i_cfg_wr && i_cfg_addr == SBC_OFS_SLAVE && idle_reg == 7'h7f;
  endsequence
  a_rsvd_reads_zero: assert property (s_csr_read |=> !o_cfg_rdata[SBC_BIT_RSVD])
    else $error("reserved bit read as one");
  a_reset_clears: assert property (@(posedge i_clk) disable iff (1'b0)
    i_rst |=> o_cfg_rdata == 8'h00 && !o_scl_oe && !o_sda_oe) else $error("reset left state");
  a_load_busy_seen: assert property (i_load_busy [*3] ##0 s_csr_read |=>
    o_cfg_rdata[SBC_BIT_ROM_BUSY]) else $error("eeprom busy not shown");
  a_load_err_sticky: assert property (s_csr_read ##0 age_reg == 2'h3 |=>
    o_cfg_rdata[SBC_BIT_LOAD_ERR] == $past(err_reg)) else $error("load error flag wrong");
  a_scl_quarter: assert property ($changed(o_scl_oe) |=> $stable(o_scl_oe) [*3])
    else $error("clock line changed inside a quarter");
  a_sda_quarter: assert property ($changed(o_sda_oe) |=> $stable(o_sda_oe) [*3])
    else $error("data line changed inside a quarter");
  a_busy_active: assert property (s_csr_read ##0 o_scl_oe |=>
    o_cfg_rdata[SBC_BIT_REQ_BUSY] || o_cfg_rdata[SBC_BIT_ROM_BUSY]) else $error("busy low");
  a_start_follows: assert property (s_slave_write |-> ##[1:40] $rose(o_sda_oe))
    else $error("no start after slave address write");
endmodule : sbc_ctrl_status_checker
bind sbc_ctrl_status sbc_ctrl_status_checker u_checker (.i_clk(i_clk), .i_rst(i_rst),
  .i_fundamental_reset(i_fundamental_reset), .i_global_reset(i_global_reset),
  .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
  .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_load_busy(i_load_busy),
  .i_load_error(i_load_error), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
`default_nettype wire

/* dv/sbc_slave_model.sv */
// behavioural two-wire slave with a byte memory, acknowledging one address
`timescale 1ns/1ns
`default_nettype none
module sbc_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // bench fault control: never acknowledge
  input wire logic i_nack,
  // high = pull data low
  output logic o_sda_oe,
  output int o_byte_cnt
);
  logic [7:0] mem [0:255];
  logic [7:0] shift;
  logic [7:0] word;
  logic rd;
  logic sel;
  logic act;
  int bitn;
  int byten;
  initial begin
    o_sda_oe = 1'b0;
    o_byte_cnt = 0;
    act = 1'b0;
  end
  // start or repeated start: data falls while clock is high
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    act = 1'b1;
    bitn = -1;
    byten = 0;
    rd = 1'b0;
    sel = 1'b0;
  end
  // stop: data rises while clock is high
  always @(posedge i_sda) if (i_scl === 1'b1) act = 1'b0;
  // sample on the rising clock, bytes come msb first
  // a master no-acknowledge after a read byte releases the slave
  always @(posedge i_scl) if (act && bitn >= 0 && bitn < 8) shift = {shift[6:0], i_sda};
  else if (act && bitn == 8 && rd && byten > 0 && i_sda) sel = 1'b0;
  // drive only while the clock is low so no false start or stop is made
  always @(negedge i_scl) if (act) begin
    if (bitn == 8) begin
      bitn = 0;
      byten++;
    end else begin
      bitn++;
    end
    if (bitn == 8) begin
      o_byte_cnt++;
      if (byten == 0) begin
        sel = (shift[7:1] == ADDR);
        rd = shift[0];
      end else if (!rd && sel && byten == 1) begin
        word = shift;
      end else if (!rd && sel) begin
        mem[word] = shift;
        word = word + 8'h01;
      end
      // acknowledge received bytes; a read byte is answered by the master
      o_sda_oe = sel && !i_nack && !(rd && byten > 0);
    end else if (rd && sel && byten > 0) begin
      o_sda_oe = !mem[word][7 - bitn];
    end else begin
      o_sda_oe = 1'b0;
    end
  end
endmodule : sbc_slave_model
`default_nettype wire

/* dv/serial_bus_control_status_test.sv */
// self-checking bench for the serial-bus control and status block
`timescale 1ns/1ns
`default_nettype none
module serial_bus_control_status_test;
  import sbc_pkg::*;
  localparam int QN = 6;
  localparam int QF = 4;
  localparam logic [6:0] SA = 7'h50;
  logic clk = 1'b0, rst = 1'b1, frst = 1'b1, global_reset = 1'b0, wr = 1'b0, rd = 1'b0;
  logic lbusy = 1'b0, lerr = 1'b0, nack = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic scl_oe, sda_oe, slv_oe, scl, sda, scl_o, sda_o;
  int fail_count = 0, samples_checked = 0, cycles = 0, cnt;
  time t0;
  // open-drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || slv_oe);
  sbc_ctrl_status #(.QTR_NORMAL(QN), .QTR_FAST(QF), .PROBE_ADDR(SA)) dut (.i_clk(clk),
    .i_rst(rst), .i_ce(1'b1), .i_fundamental_reset(frst), .i_global_reset(global_reset),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .i_load_busy(lbusy), .i_load_error(lerr), .i_sda(sda),
    .o_scl(scl_o), .o_scl_oe(scl_oe), .o_sda(sda_o), .o_sda_oe(sda_oe));
  sbc_slave_model #(.ADDR(SA)) u_slave (.i_scl(scl), .i_sda(sda), .i_nack(nack),
    .o_sda_oe(slv_oe), .o_byte_cnt(cnt));
  initial forever #5 clk = !clk;
  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // hang guard: the run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check_eq
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {wr, addr, wdata} = {1'b1, a, d};
    @(posedge clk) #1 wr = 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 {rd, addr} = {1'b1, a};
    @(posedge clk) #1 rd = 1'b0;
    d = rdata;
  endtask : cfg_rd
  // poll both busy flags, then leave the bus quiet long enough to be idle
  task automatic wait_idle;
    v = 8'hff;
    for (int i = 0; i < 3000 && (v & 8'h30) !== 8'h00; i++) cfg_rd(SBC_OFS_CSR, v);
    check_eq(v & 8'h30, 8'h00);
    repeat (130) @(posedge clk);
  endtask : wait_idle
  task automatic xfer(input logic [7:0] s, input int bytes);
    int c0;
    c0 = cnt;
    cfg_wr(SBC_OFS_SLAVE, s);
    wait_idle();
    check_eq(8'(cnt - c0), 8'(bytes));
  endtask : xfer
  // probe after fundamental reset release finds the eeprom
  task automatic t_probe;
    repeat (4) @(posedge clk);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h10);
    wait_idle();
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h08);
  endtask : t_probe
  // access kinds, reserved bit and unmapped offset
  task automatic t_regs;
    cfg_wr(SBC_OFS_CSR, 8'hff);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h8c);
    cfg_wr(SBC_OFS_CSR, 8'h00);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h00);
    cfg_rd(8'hb7, v);
    check_eq(v, 8'h00);
  endtask : t_regs
  // mode 0 write then read back, fast clock measured bit to bit
  task automatic t_mode0;
    cfg_wr(SBC_OFS_CSR, 8'h04);
    cfg_wr(SBC_OFS_DATA, 8'hc3);
    cfg_wr(SBC_OFS_WORD, 8'h21);
    cfg_wr(SBC_OFS_SLAVE, {SA, 1'b0});
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h24);
    @(posedge scl);
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    check_eq(8'(($time - t0) / 10), 8'(4 * QF));
    wait_idle();
    check_eq(u_slave.mem[8'h21], 8'hc3);
    cfg_wr(SBC_OFS_DATA, 8'h00);
    xfer({SA, 1'b1}, 4);
    cfg_rd(SBC_OFS_DATA, v);
    check_eq(v, 8'hc3);
  endtask : t_mode0
  // mode 1: slave address only, normal clock
  task automatic t_mode1;
    cfg_wr(SBC_OFS_CSR, 8'h80);
    cfg_wr(SBC_OFS_DATA, 8'h21);
    cfg_wr(SBC_OFS_SLAVE, {SA, 1'b0});
    @(posedge scl);
    @(posedge scl);
    t0 = $time;
    @(posedge scl);
    check_eq(8'(($time - t0) / 10), 8'(4 * QN));
    wait_idle();
    cfg_wr(SBC_OFS_DATA, 8'h00);
    xfer({SA, 1'b1}, 2);
    cfg_rd(SBC_OFS_DATA, v);
    check_eq(v, 8'hc3);
  endtask : t_mode1
  // missing acknowledge: stop, sticky error, cleared by writing one
  task automatic t_nack;
    nack = 1'b1;
    cfg_wr(SBC_OFS_CSR, 8'h04);
    xfer({SA, 1'b0}, 1);
    check_eq({6'h00, scl, sda}, 8'h03);
    check_eq({6'h00, scl_o, sda_o}, 8'h00);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h06);
    cfg_wr(SBC_OFS_CSR, 8'h06);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h04);
    nack = 1'b0;
  endtask : t_nack
  // external loader busy level and error pulse
  task automatic t_loader;
    @(posedge clk) #1 lbusy = 1'b1;
    repeat (4) @(posedge clk);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h14);
    @(posedge clk) #1 {lbusy, lerr} = 2'b01;
    @(posedge clk) #1 lerr = 1'b0;
    repeat (4) @(posedge clk);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h05);
    cfg_wr(SBC_OFS_CSR, 8'h05);
    cfg_rd(SBC_OFS_CSR, v);
    check_eq(v, 8'h04);
  endtask : t_loader
  // global reset returns every register to zero
  task automatic t_global;
    cfg_wr(SBC_OFS_CSR, 8'h8c);
    cfg_wr(SBC_OFS_DATA, 8'h11);
    @(posedge clk) #1 global_reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 global_reset = 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      cfg_rd(SBC_OFS_DATA + 8'(a), v);
      check_eq(v, 8'h00);
    end
  endtask : t_global
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    // fundamental reset outlasts power-on reset so its release is seen and probes
    repeat (4) @(posedge clk);
    #1 frst = 1'b0;
    t_probe();
    t_regs();
    t_mode0();
    t_mode1();
    t_nack();
    t_loader();
    t_global();
    end_sim();
  end
endmodule : serial_bus_control_status_test
`default_nettype wire
